/* rtl/aldp_pkg.sv */
package aldp_pkg;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_ACC      = 8'h00;
   localparam logic [7:0] OFS_FLAGS    = 8'h04;
   localparam logic [7:0] OFS_PAIR0    = 8'h08; // six pair words
   localparam logic [7:0] OFS_INSTR_LO = 8'h20;
   localparam logic [7:0] OFS_INSTR_HI = 8'h24;
   localparam logic [7:0] OFS_MEM_OPND = 8'h28;
   localparam logic [7:0] OFS_CTRL     = 8'h2C;
   localparam logic [7:0] OFS_EFF_ADDR = 8'h30;

   // control and status bit positions
   localparam int CTRL_START   = 0;
   localparam int STAT_DONE    = 0;
   localparam int STAT_ILLEGAL = 1;
   localparam int STAT_MEM     = 2;

   // reset value of every register
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // pair file indices
   localparam int         PAIR_CNT     = 6;
   localparam logic [2:0] PR_COUNT     = 3'h0;
   localparam logic [2:0] PR_SECOND    = 3'h1;
   localparam logic [2:0] PR_POINTER   = 3'h2;
   localparam logic [2:0] PR_INDEX_ONE = 3'h3;
   localparam logic [2:0] PR_INDEX_TWO = 3'h4;
   localparam logic [2:0] PR_STACK     = 3'h5;

   // opcode fields
   localparam logic [7:0] PFX_EXT    = 8'hED;
   localparam logic [4:0] PFX_INDEX  = 5'h1D; // low bits of index prefix
   localparam logic [7:0] ADD_A_OP   = 8'h6D;
   localparam logic [1:0] GRP_LOW    = 2'h0;
   localparam logic [1:0] GRP_ED1    = 2'h1;
   localparam logic [1:0] GRP_ALU8   = 2'h2;
   localparam logic [1:0] GRP_HI     = 2'h3;
   localparam logic [3:0] ADC_LOW    = 4'hA;
   localparam logic [3:0] ADD16_LOW  = 4'h9;
   localparam logic [2:0] IMM_LOW    = 3'h6;
   localparam logic [2:0] OPF_ADD    = 3'h0;
   localparam logic [2:0] OPF_AND    = 3'h4;
   localparam logic [2:0] R8_MEM     = 3'h6;
   localparam logic [2:0] R8_ACC     = 3'h7;
   localparam logic [2:0] RX_HIGH    = 3'h4;
   localparam logic [2:0] RX_LOW     = 3'h5;
   localparam logic [2:0] F8_DIRECT  = 3'h7;
   localparam logic [2:0] F8_REL     = 3'h0;
   localparam logic [2:0] W_INDEXED  = 3'h4;
   localparam logic [2:0] W_IMM_REL  = 3'h6;
   localparam logic [1:0] BASE_ONE   = 2'h1;
   localparam logic [1:0] BASE_TWO   = 2'h2;

   typedef struct packed {
      logic s;
      logic z;
      logic y;
      logic h;
      logic x;
      logic pv;
      logic n;
      logic c;
   } aldp_flags_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } aldp_wb_req_t;

   typedef enum logic [2:0] {
      OP_NONE, OP_ADD8, OP_AND8, OP_ADD16, OP_ADC16, OP_ADDA16, OP_WORD_SUM_OP
   } aldp_op_t;

endpackage

/* rtl/aldp_datapath.sv */
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps

module aldp_datapath
   import aldp_pkg::*;
(
   input  logic         ref_clk,
   input  logic         reset,
   input  aldp_wb_req_t wb_req,
   output logic         wb_ack_o,
   output logic [31:0]  wb_dat_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  acc;
   aldp_flags_t flags;
   logic [15:0] pairs [PAIR_CNT];
   logic [31:0] instr_lo;
   logic [7:0]  b4;
   logic [15:0] mem_opnd;
   logic        exec_go;
   logic        done;
   logic        illegal;
   logic        mem_flag;
   logic [15:0] eff_addr;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   logic        req;
   logic        wr;
   logic [7:0]  wadr;
   logic        pair_hit;
   logic [2:0]  pair_bus;
   logic [31:0] rdata;
   logic [31:0] wnew;

   // byte lanes take new data only where sel is high
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  sel);
      for (int i = 0; i < 4; i++) begin
         lane_merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

   // request seen once per cycle, ack gap keeps it single
   assign req      = wb_req.cyc & wb_req.stb & ~wb_ack_o;
   // writes land at the edge that samples ack, while the master still holds
   assign wr       = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack_o;
   assign wadr     = {wb_req.adr[7:2], 2'b00};
   assign pair_hit = (wadr >= OFS_PAIR0) && (wadr < OFS_INSTR_LO);
   assign pair_bus = 3'((wadr - OFS_PAIR0) >> 2);
   assign wnew     = lane_merge(rdata, wb_req.dat, wb_req.sel);

   // read mux, unmapped words read zero
   always_comb begin
      rdata = RST_WORD;
      if (pair_hit) begin
         rdata[15:0] = pairs[pair_bus];
      end else begin
         case (wadr)
            OFS_ACC:      rdata[7:0]  = acc;
            OFS_FLAGS:    rdata[7:0]  = flags;
            OFS_INSTR_LO: rdata       = instr_lo;
            OFS_INSTR_HI: rdata[7:0]  = b4;
            OFS_MEM_OPND: rdata[15:0] = mem_opnd;
            OFS_CTRL: begin
               rdata[STAT_DONE]    = done;
               rdata[STAT_ILLEGAL] = illegal;
               rdata[STAT_MEM]     = mem_flag;
            end
            OFS_EFF_ADDR: rdata[15:0] = eff_addr;
            default:      rdata       = RST_WORD;
         endcase
      end
   end

   // ------------------------------------------------------------
   // opcode decode
   // ------------------------------------------------------------
   logic [7:0]  b0, b1, b2, b3, eb;
   logic        pfx_x, pfx_e, ext, phi;
   logic [2:0]  xsel, dst, ext_dst, f8;
   logic [15:0] dd8, dd16, sx8;
   aldp_op_t    op;
   logic [7:0]  src8;
   logic [15:0] src16;
   logic        use_mem;
   logic [15:0] ea;

   assign b0 = instr_lo[7:0];
   assign b1 = instr_lo[15:8];
   assign b2 = instr_lo[23:16];
   assign b3 = instr_lo[31:24];
   assign pfx_x = (b0[7:6] == GRP_HI) && (b0[4:0] == PFX_INDEX);
   assign pfx_e = (b0 == PFX_EXT);
   assign phi   = b0[5];
   assign xsel  = phi ? PR_INDEX_TWO : PR_INDEX_ONE;
   assign ext   = pfx_e || (pfx_x && b1 == PFX_EXT);
   assign eb    = pfx_x ? b2 : b1;
   assign ext_dst = pfx_x ? xsel : PR_POINTER;
   assign dd8   = {b3, b2};
   assign dd16  = pfx_x ? {b4, b3} : {b3, b2};
   assign sx8   = {{8{b2[7]}}, b2};
   assign f8    = b1[2:0];

   // operation field to byte operation
   function automatic aldp_op_t alu8_op(input logic [2:0] f);
      case (f)
         OPF_ADD: alu8_op = OP_ADD8;
         OPF_AND: alu8_op = OP_AND8;
         default: alu8_op = OP_NONE;
      endcase
   endfunction

   // word source field: count, second, self, stack
   function automatic logic [2:0] pidx(input logic [1:0] f,
                                       input logic [2:0] self);
      case (f)
         2'h0:    pidx = PR_COUNT;
         2'h1:    pidx = PR_SECOND;
         2'h2:    pidx = self;
         default: pidx = PR_STACK;
      endcase
   endfunction

   // picks operation, destination, operand and effective address
   always_comb begin
      op      = OP_NONE;
      dst     = PR_POINTER;
      src8    = mem_opnd[7:0];
      src16   = mem_opnd;
      use_mem = 1'b0;
      ea      = RST_WORD[15:0];
      if (ext) begin
         if (eb[7:6] == GRP_ED1 && eb[3:0] == ADC_LOW) begin
            op    = OP_ADC16;
            dst   = ext_dst;
            src16 = pairs[pidx(eb[5:4], ext_dst)];
         end else if (eb == ADD_A_OP) begin
            op    = OP_ADDA16;
            dst   = ext_dst;
            src16 = {{8{acc[7]}}, acc};
         end else if (eb[7:6] == GRP_HI && eb[2:0] == IMM_LOW
                      && !eb[3]) begin
            op = OP_WORD_SUM_OP;
            if (!pfx_x) begin
               src16 = pairs[pidx(eb[5:4], PR_POINTER)];
            end else begin
               case (eb[5:3])
                  W_INDEXED: src16 = pairs[xsel];
                  W_IMM_REL: begin
                     src16   = phi ? dd16 : mem_opnd;
                     use_mem = !phi;
                     ea      = dd16;
                  end
                  3'h0, 3'h2: begin
                     use_mem = 1'b1;
                     if (phi) begin
                        ea = pairs[eb[4] ? PR_INDEX_TWO : PR_INDEX_ONE]
                             + dd16;
                     end else begin
                        ea = eb[4] ? dd16 : pairs[PR_POINTER];
                     end
                  end
                  default: op = OP_NONE;
               endcase
            end
         end
      end else if (!pfx_x) begin
         if (b0[7:6] == GRP_ALU8) begin
            op      = alu8_op(b0[5:3]);
            use_mem = (b0[2:0] == R8_MEM);
            ea      = pairs[PR_POINTER];
            if (b0[2:0] == R8_ACC) begin
               src8 = acc;
            end else if (!use_mem) begin
               src8 = b0[0] ? pairs[{1'b0, b0[2:1]}][7:0]
                            : pairs[{1'b0, b0[2:1]}][15:8];
            end
         end else if (b0[7:6] == GRP_HI && b0[2:0] == IMM_LOW) begin
            op   = alu8_op(b0[5:3]);
            src8 = b1;
         end else if (b0[7:6] == GRP_LOW && b0[3:0] == ADD16_LOW) begin
            op    = OP_ADD16;
            src16 = pairs[pidx(b0[5:4], PR_POINTER)];
         end
      end else if (b1[7:6] == GRP_LOW && b1[3:0] == ADD16_LOW) begin
         op    = OP_ADD16;
         dst   = xsel;
         src16 = pairs[pidx(b1[5:4], xsel)];
      end else if (b1[7:6] == GRP_ALU8) begin
         op      = alu8_op(b1[5:3]);
         use_mem = 1'b1;
         case (f8)
            RX_HIGH: begin
               src8    = pairs[xsel][15:8];
               use_mem = 1'b0;
            end
            RX_LOW: begin
               src8    = pairs[xsel][7:0];
               use_mem = 1'b0;
            end
            F8_DIRECT: begin
               ea = dd8;
               if (phi) begin
                  op = OP_NONE;
               end
            end
            R8_MEM:  ea = pairs[xsel] + sx8;
            F8_REL:  ea = phi ? dd8 : pairs[PR_STACK] + dd8;
            default: begin
               if (phi) begin
                  ea = (f8[1:0] == BASE_ONE) ? pairs[PR_INDEX_ONE] + dd8
                     : (f8[1:0] == BASE_TWO) ? pairs[PR_INDEX_TWO] + dd8
                     : pairs[PR_POINTER] + dd8;
               end else begin
                  ea = (f8[1:0] == BASE_ONE)
                       ? pairs[PR_POINTER] + pairs[PR_INDEX_ONE]
                     : (f8[1:0] == BASE_TWO)
                       ? pairs[PR_POINTER] + pairs[PR_INDEX_TWO]
                     : pairs[PR_INDEX_ONE] + pairs[PR_INDEX_TWO];
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // arithmetic
   // ------------------------------------------------------------
   logic [15:0] a16;
   logic        cin;
   logic [16:0] sum17;
   logic [12:0] low13;
   logic        v16;
   logic [8:0]  sum9;
   logic [4:0]  low5;
   logic        v8;
   logic [7:0]  and8;

   assign a16   = pairs[dst];
   assign cin   = (op == OP_ADC16) & flags.c;
   assign sum17 = {1'b0, a16} + {1'b0, src16} + {16'h0000, cin};
   assign low13 = {1'b0, a16[11:0]} + {1'b0, src16[11:0]}
                  + {12'h000, cin};
   assign v16   = (a16[15] == src16[15]) && (sum17[15] != a16[15]);
   assign sum9  = {1'b0, acc} + {1'b0, src8};
   assign low5  = {1'b0, acc[3:0]} + {1'b0, src8[3:0]};
   assign v8    = (acc[7] == src8[7]) && (sum9[7] != acc[7]);
   assign and8  = acc & src8;

   // ------------------------------------------------------------
   // accumulator and flags
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         acc   <= RST_WORD[7:0];
         flags <= RST_WORD[7:0];
      end else if (exec_go) begin
         case (op)
            OP_ADD8: begin
               acc      <= sum9[7:0];
               flags.s  <= sum9[7];
               flags.z  <= (sum9[7:0] == 8'h00);
               flags.h  <= low5[4];
               flags.pv <= v8;
               flags.n  <= 1'b0;
               flags.c  <= sum9[8];
            end
            OP_AND8: begin
               acc      <= and8;
               flags.s  <= and8[7];
               flags.z  <= (and8 == 8'h00);
               flags.pv <= ~^and8;
               flags.n  <= 1'b0;
               flags.c  <= 1'b0;
            end
            OP_ADD16: begin
               flags.h <= low13[12];
               flags.n <= 1'b0;
               flags.c <= sum17[16];
            end
            OP_ADC16, OP_ADDA16, OP_WORD_SUM_OP: begin
               flags.s  <= sum17[15];
               flags.z  <= (sum17[15:0] == 16'h0000);
               flags.h  <= low13[12];
               flags.pv <= v16;
               flags.n  <= 1'b0;
               flags.c  <= sum17[16];
            end
            default: acc <= acc;
         endcase
      end else if (wr && wadr == OFS_ACC) begin
         acc <= wnew[7:0];
      end else if (wr && wadr == OFS_FLAGS) begin
         flags <= wnew[7:0];
      end
   end

   // ------------------------------------------------------------
   // pair file, one entry per generate step
   // ------------------------------------------------------------
   generate
      for (genvar g = 0; g < PAIR_CNT; g++) begin : pair_entry
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               pairs[g] <= RST_WORD[15:0];
            end else if (exec_go && dst == 3'(g) && (op == OP_ADD16
                         || op == OP_ADC16 || op == OP_ADDA16
                         || op == OP_WORD_SUM_OP)) begin
               pairs[g] <= sum17[15:0];
            end else if (wr && pair_hit && pair_bus == 3'(g)) begin
               pairs[g] <= wnew[15:0];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // instruction, operand and status registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         instr_lo <= RST_WORD;
         b4       <= RST_WORD[7:0];
         mem_opnd <= RST_WORD[15:0];
      end else if (wr) begin
         if (wadr == OFS_INSTR_LO) instr_lo <= wnew;
         if (wadr == OFS_INSTR_HI) b4 <= wnew[7:0];
         if (wadr == OFS_MEM_OPND) mem_opnd <= wnew[15:0];
      end
   end

   // start pulse one cycle after the control write
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         exec_go <= 1'b0;
      end else begin
         exec_go <= wr && wadr == OFS_CTRL && wnew[CTRL_START];
      end
   end

   // status capture, execution wins over clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         done     <= 1'b0;
         illegal  <= 1'b0;
         mem_flag <= 1'b0;
         eff_addr <= RST_WORD[15:0];
      end else if (exec_go) begin
         done     <= 1'b1;
         illegal  <= (op == OP_NONE);
         mem_flag <= use_mem;
         eff_addr <= ea;
      end else if (wr && wadr == OFS_CTRL) begin
         done <= 1'b0;
      end
   end

   // bus answer, one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= RST_WORD;
      end else begin
         wb_ack_o <= req;
         if (req) wb_dat_o <= rdata;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   adc_sum_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == PFX_EXT && b1 == 8'h4A |=>
      pairs[PR_POINTER] == $past(pairs[PR_POINTER])
         + $past(pairs[PR_COUNT]) + $past(flags.c)
      && $stable(pairs[PR_COUNT]))
   else $error("word add with carry wrong");

   adc_flags_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == PFX_EXT && b1 == 8'h4A |=> !flags.n
      && flags.s == pairs[PR_POINTER][15]
      && flags.z == (pairs[PR_POINTER] == 16'h0000))
   else $error("word add with carry flags wrong");

   half_word_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'h09 |=> flags.h ==
      |(({1'b0, $past(pairs[PR_POINTER][11:0])}
        + {1'b0, $past(pairs[PR_COUNT][11:0])}) >> 12))
   else $error("word half carry wrong");

   add_word_keep_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'h09 |=> $stable(flags.s) && $stable(flags.z)
      && $stable(flags.pv) && !flags.n)
   else $error("plain word add touched kept flags");

   add_acc_sext_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == PFX_EXT && b1 == ADD_A_OP |=>
      pairs[PR_POINTER] == $past(pairs[PR_POINTER])
         + {{8{$past(acc[7])}}, $past(acc)} && $stable(acc))
   else $error("accumulator add not sign extended");

   add_byte_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'h80 |=>
      acc == $past(acc) + $past(pairs[PR_COUNT][15:8]) && !flags.n)
   else $error("byte add result wrong");

   half_byte_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'h80 |=> flags.h ==
      |(({1'b0, $past(acc[3:0])}
        + {1'b0, $past(pairs[PR_COUNT][11:8])}) >> 4))
   else $error("byte half carry wrong");

   and_byte_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'hA0 |=>
      acc == ($past(acc) & $past(pairs[PR_COUNT][15:8]))
      && !flags.c && flags.pv == ~^acc)
   else $error("and result or flags wrong");

   index_byte_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'hFD && b1 == 8'h84 |=>
      acc == $past(acc) + $past(pairs[PR_INDEX_TWO][15:8]))
   else $error("index high byte not used");

   direct_addr_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'hDD && b1 == 8'h87 |=>
      eff_addr == {$past(b3), $past(b2)} && mem_flag)
   else $error("direct address wrong");

   word_imm_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      exec_go && b0 == 8'hFD && b1 == PFX_EXT && b2 == 8'hF6 |=>
      pairs[PR_POINTER] == $past(pairs[PR_POINTER])
         + {$past(b4), $past(b3)})
   else $error("word immediate wrong");

   bus_ack_a:
   assert property (@(posedge ref_clk) disable iff (reset)
      req |=> wb_ack_o ##1 !wb_ack_o)
   else $error("ack not a single cycle");

endmodule

/* bench/tb_aldp_datapath.sv */
`timescale 1ns/1ps
module tb_aldp_datapath
   import aldp_pkg::*;
   ;
   localparam logic [7:0] AD_CNT = OFS_PAIR0;
   localparam logic [7:0] AD_SEC = OFS_PAIR0 + 8'h04;
   localparam logic [7:0] AD_PTR = OFS_PAIR0 + 8'h08;
   localparam logic [7:0] AD_IX1 = OFS_PAIR0 + 8'h0C;
   localparam logic [7:0] AD_IX2 = OFS_PAIR0 + 8'h10;

   logic         ref_clk;
   logic         reset;
   aldp_wb_req_t wb_req;
   logic         wb_ack_o;
   logic [31:0]  wb_dat_o;
   logic [31:0]  rv;
   int           num_errors;
   int           n_checks;

   // ----------------------------------------------------------
   // clock and device
   // ----------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   aldp_datapath aldp_datapath_inst (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .wb_req   (wb_req),
      .wb_ack_o (wb_ack_o),
      .wb_dat_o (wb_dat_o)
   );

   // ----------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------
   // one classic cycle, held until ack is sampled
   task automatic wb_cyc(input logic we, input logic [7:0] a,
                         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      if (wb_ack_o !== 1'b1) num_errors++;
      rv = wb_dat_o;
      wb_req <= '0;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t read %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb_cyc(1'b0, a, 32'h0000_0000);
      chk(rv, exp);
   endtask

   // load instruction bytes and start it
   task automatic run(input logic [31:0] lo);
      wb_cyc(1'b1, OFS_INSTR_LO, lo);
      wb_cyc(1'b1, OFS_INSTR_HI, 32'h0000_0000);
      wb_cyc(1'b1, OFS_CTRL, 32'h0000_0001);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------
   // watchdog
   // ----------------------------------------------------------
   initial begin
      #200000;
      num_errors++;
      end_of_test();
   end

   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial begin
      wb_req = '0;
      reset = 1'b1;
      num_errors = 0;
      n_checks = 0;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rd_chk(OFS_ACC, RST_WORD);
      rd_chk(8'hFC, 32'h0000_0000); // unmapped place reads zero
      // word add with carry into pointer pair
      wb_cyc(1'b1, AD_CNT, 32'h0000_2308);
      wb_cyc(1'b1, AD_PTR, 32'h0000_F038);
      wb_cyc(1'b1, OFS_FLAGS, 32'h0000_0001);
      run(32'h0000_4AED);
      rd_chk(AD_PTR, 32'h0000_1341);
      rd_chk(OFS_FLAGS, 32'h0000_0001);
      rd_chk(AD_CNT, 32'h0000_2308);
      $display("test word add with carry done");
      // sign-extended accumulator add
      wb_cyc(1'b1, AD_PTR, 32'h0000_2384);
      wb_cyc(1'b1, OFS_ACC, 32'h0000_00E2);
      wb_cyc(1'b1, OFS_FLAGS, 32'h0000_0000);
      run(32'h0000_6DED);
      rd_chk(AD_PTR, 32'h0000_2366);
      rd_chk(OFS_FLAGS, 32'h0000_0011);
      rd_chk(OFS_ACC, 32'h0000_00E2);
      $display("test accumulator add done");
      // plain word add keeps S Z V, then both index forms
      wb_cyc(1'b1, AD_PTR, 32'h0000_F038);
      wb_cyc(1'b1, OFS_FLAGS, 32'h0000_00C6);
      run(32'h0000_0009);
      rd_chk(AD_PTR, 32'h0000_1340);
      rd_chk(OFS_FLAGS, 32'h0000_00C5);
      wb_cyc(1'b1, AD_IX1, 32'h0000_1000);
      wb_cyc(1'b1, AD_IX2, 32'h0000_0001);
      run(32'h0000_09DD);
      rd_chk(AD_IX1, 32'h0000_3308);
      run(32'h0000_09FD);
      rd_chk(AD_IX2, 32'h0000_2309);
      $display("test plain word add done");
      // word add of second pair
      wb_cyc(1'b1, AD_SEC, 32'h0000_0010);
      wb_cyc(1'b1, AD_PTR, 32'h0000_A123);
      run(32'h0000_D6ED);
      rd_chk(AD_PTR, 32'h0000_A133);
      rd_chk(OFS_FLAGS, 32'h0000_0080);
      $display("test word sum done");
      // byte add from count pair high byte
      wb_cyc(1'b1, AD_CNT, 32'h0000_1800);
      wb_cyc(1'b1, OFS_ACC, 32'h0000_0048);
      run(32'h0000_0080);
      rd_chk(OFS_ACC, 32'h0000_0060);
      rd_chk(OFS_FLAGS, 32'h0000_0010);
      // byte add, direct form with overflow
      wb_cyc(1'b1, OFS_ACC, 32'h0000_0001);
      wb_cyc(1'b1, OFS_MEM_OPND, 32'h0000_007F);
      run(32'h3412_87DD);
      rd_chk(OFS_ACC, 32'h0000_0080);
      rd_chk(OFS_FLAGS, 32'h0000_0094);
      rd_chk(OFS_EFF_ADDR, 32'h0000_3412);
      rd_chk(OFS_CTRL, 32'h0000_0005);
      $display("test byte add done");
      // and with immediate, even parity
      wb_cyc(1'b1, OFS_ACC, 32'h0000_0048);
      wb_cyc(1'b1, OFS_FLAGS, 32'h0000_0013);
      run(32'h0000_4FE6);
      rd_chk(OFS_ACC, 32'h0000_0048);
      rd_chk(OFS_FLAGS, 32'h0000_0014);
      // unsupported code leaves state alone
      run(32'h0000_00FF);
      rd_chk(OFS_CTRL, 32'h0000_0003);
      rd_chk(OFS_ACC, 32'h0000_0048);
      $display("test and and refusal done");
      // index high byte, and from count pair, word immediate
      wb_cyc(1'b1, OFS_ACC, 32'h0000_0010);
      run(32'h0000_84FD);
      rd_chk(OFS_ACC, 32'h0000_0033);
      wb_cyc(1'b1, OFS_ACC, 32'h0000_009B);
      run(32'h0000_00A0);
      rd_chk(OFS_ACC, 32'h0000_0018);
      rd_chk(OFS_FLAGS, 32'h0000_0004);
      wb_cyc(1'b1, OFS_INSTR_LO, 32'h01F6_EDFD);
      wb_cyc(1'b1, OFS_INSTR_HI, 32'h0000_0010);
      wb_cyc(1'b1, OFS_CTRL, 32'h0000_0001);
      rd_chk(AD_PTR, 32'h0000_B134);
      rd_chk(OFS_FLAGS, 32'h0000_0080);
      // base-index and long-displacement indexed addresses
      run(32'h0000_81DD);
      rd_chk(OFS_EFF_ADDR, 32'h0000_E43C);
      run(32'h0010_83FD);
      rd_chk(OFS_EFF_ADDR, 32'h0000_B144);
      $display("test index and addressing forms done");
      end_of_test();
   end
endmodule
